// ### verif/iqofs_regs_checker.sv
// Concurrent checks on the ports of the IQ offset register bank.
`timescale 1ns/100ps
`default_nettype none
module iqofs_regs_checker
  import iqofs_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              fifoSyncIn,
  input wire logic [PTR_W-1:0]  fifoReadPtr,
  input wire logic              fifoPtrLoad,
  input wire logic              autoSyncPulse,
  input wire iqofs_corr_s       corr
);
  // All checks run on the system clock and pause while reset is low.
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Handshake steps that start a write, a read and a FIFO sync.
  sequence sWrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence sRdTaken;
    arvalid && arready;
  endsequence
  sequence sSyncRise;
    $rose(fifoSyncIn);
  endsequence

  // Bus answers arrive in bounded time and hold until taken.
  a_write_answer: assert property (sWrTaken |-> ##[1:4] bvalid)
    else $error("write response did not arrive in time");
  a_read_answer: assert property (sRdTaken |-> ##[1:4] rvalid)
    else $error("read data did not arrive in time");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before it was taken");

  // The read pointer changes only at a sync load, which follows the pin edge.
  a_ptr_load: assert property (sSyncRise |-> ##[2:4] fifoPtrLoad)
    else $error("sync edge did not load the read pointer");
  a_ptr_cause: assert property ($changed(fifoReadPtr) |-> fifoPtrLoad)
    else $error("read pointer moved without a load");
  a_load_single: assert property (fifoPtrLoad |=> !fifoPtrLoad)
    else $error("pointer load pulse too long");

  // Applied offsets move only as a pair at an auto-sync.
  a_cd_pair: assert property ($changed({corr.offC, corr.offD}) |-> autoSyncPulse)
    else $error("C/D offsets changed without an auto-sync");
  a_ab_pair: assert property ($changed({corr.offA, corr.offB}) |-> autoSyncPulse)
    else $error("A/B offsets changed without an auto-sync");
  a_sync_single: assert property (autoSyncPulse |=> !autoSyncPulse)
    else $error("auto-sync pulse too long");
endmodule
bind iqofs_regs iqofs_regs_checker #(.SYNC_STAGES(SYNC_STAGES)) i_iqofs_regs_checker (
  .clk_sys(clk_sys), .resetn(resetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .fifoSyncIn(fifoSyncIn), .fifoReadPtr(fifoReadPtr), .fifoPtrLoad(fifoPtrLoad),
  .autoSyncPulse(autoSyncPulse), .corr(corr)
);
`default_nettype wire

// ### verif/iqofs_regs_tb.sv
// Self-checking testbench of the IQ offset register bank.
`timescale 1ns/100ps
`default_nettype none
module iqofs_regs_tb
  import iqofs_pkg::*;
;
  logic              clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready, fifoSyncIn;
  logic              awready, wready, bvalid, arready, rvalid, fifoPtrLoad, autoSyncPulse;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [PTR_W-1:0]  fifoReadPtr;
  iqofs_corr_s       corr;
  int                mismatches, checks;

  iqofs_regs #(.SYNC_STAGES(2)) i_iqofs_regs (
    .clk_sys(clk_sys), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fifoSyncIn(fifoSyncIn), .fifoReadPtr(fifoReadPtr), .fifoPtrLoad(fifoPtrLoad),
    .autoSyncPulse(autoSyncPulse), .corr(corr)
  );

  // Free-running 40 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Compares one value with its expectation and counts the outcome.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One register write; bready stands from the start until the response is taken.
  task automatic reg_write(input logic [7:0] idx, input logic [15:0] val,
                           input logic [3:0] strb, input logic [1:0] expResp);
    int   waitCnt;
    logic done;
    @(posedge clk_sys);
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= {16'h0000, val};
    wstrb   <= strb;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    for (waitCnt = 0; !done && waitCnt < 50; waitCnt++)
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        done = 1'b1;
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, expResp});
      end
    end
    check("write answered", {31'h0, done}, 32'h1);
    if (!done) end_sim;
  endtask

  // One register read; rready stands from the start until the data is taken.
  task automatic reg_read(input logic [7:0] idx, input logic [15:0] exp,
                          input logic [1:0] expResp);
    int   waitCnt;
    logic done;
    @(posedge clk_sys);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done = 1'b0;
    for (waitCnt = 0; !done && waitCnt < 50; waitCnt++)
    begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        done = 1'b1;
        rready <= 1'b0;
        check("rdata", rdata, {16'h0000, exp});
        check("rresp", {30'h0, rresp}, {30'h0, expResp});
      end
    end
    check("read answered", {31'h0, done}, 32'h1);
    if (!done) end_sim;
  endtask

  // Raises the sync pin, waits for the pointer load and checks the loaded value.
  task automatic fifo_sync(input logic [2:0] expPtr);
    int waitCnt;
    @(posedge clk_sys);
    fifoSyncIn <= 1'b1;
    @(posedge clk_sys);
    for (waitCnt = 0; fifoPtrLoad !== 1'b1 && waitCnt < 10; waitCnt++)
      @(posedge clk_sys);
    check("pointer load", {31'h0, fifoPtrLoad}, 32'h1);
    check("fifo pointer", {29'h0, fifoReadPtr}, {29'h0, expPtr});
    fifoSyncIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // Watchdog that ends a hung run.
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    end_sim;
  end

  // Main sequence of tests.
  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, fifoSyncIn} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    mismatches = 0;
    checks = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    reg_read(IDX_OFS_A, 16'h0000, RESP_OKAY);
    reg_read(IDX_PRESET_B, 16'h8000, RESP_OKAY);
    reg_read(IDX_OFS_C, 16'h0000, RESP_OKAY);
    reg_read(IDX_OFS_D, 16'h0000, RESP_OKAY);
    reg_read(IDX_GAIN_A, 16'h0400, RESP_OKAY);
    check("fifo pointer", {29'h0, fifoReadPtr}, 32'h4);
    check("gain applied", {21'h0, corr.gainA}, 32'h400);
    $display("reset test done");
    reg_write(IDX_GAIN_A, 16'h07FF, 4'hF, RESP_OKAY);
    reg_read(IDX_GAIN_A, 16'h07FF, RESP_OKAY);
    check("gain applied", {21'h0, corr.gainA}, 32'h7FF);
    $display("gain test done");
    reg_write(IDX_OFS_D, 16'h1ABC, 4'hF, RESP_OKAY);
    check("offset d", {19'h0, corr.offD}, 32'h0);
    reg_read(IDX_OFS_D, 16'h1ABC, RESP_OKAY);
    reg_write(IDX_OFS_D, 16'h00FF, 4'h1, RESP_OKAY);
    reg_read(IDX_OFS_D, 16'h1AFF, RESP_OKAY);
    reg_write(IDX_OFS_C, 16'h0123, 4'hF, RESP_OKAY);
    check("offset c", {19'h0, corr.offC}, 32'h123);
    check("offset d", {19'h0, corr.offD}, 32'h1AFF);
    reg_write(IDX_PRESET_B, 16'h2055, 4'hF, RESP_OKAY);
    check("offset b", {19'h0, corr.offB}, 32'h0);
    reg_write(IDX_OFS_A, 16'h0777, 4'hF, RESP_OKAY);
    check("offset a", {19'h0, corr.offA}, 32'h777);
    check("offset b", {19'h0, corr.offB}, 32'h055);
    $display("offset pair test done");
    fifo_sync(3'h1);
    reg_write(IDX_PRESET_B, 16'hE055, 4'hF, RESP_OKAY);
    check("fifo pointer", {29'h0, fifoReadPtr}, 32'h1);
    fifo_sync(3'h7);
    reg_read(IDX_STATUS, 16'h0207, RESP_OKAY);
    $display("fifo sync test done");
    reg_write(IDX_SYNC_CFG, 16'h0000, 4'hF, RESP_OKAY);
    reg_write(IDX_OFS_C, 16'h0FFF, 4'hF, RESP_OKAY);
    check("offset c", {19'h0, corr.offC}, 32'h123);
    reg_read(IDX_OFS_C, 16'h0FFF, RESP_OKAY);
    reg_write(IDX_STATUS, 16'h0000, 4'hF, RESP_SLVERR);
    reg_write(8'h20, 16'h1234, 4'hF, RESP_SLVERR);
    reg_read(8'h20, 16'h0000, RESP_SLVERR);
    $display("refusal test done");
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    reg_read(IDX_PRESET_B, 16'h8000, RESP_OKAY);
    check("offset c", {19'h0, corr.offC}, 32'h0);
    $display("second reset test done");
    end_sim;
  end
endmodule
`default_nettype wire

// ### verilog/iqofs_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/100ps
`default_nettype none
module iqofs_axil_slave
  import iqofs_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output iqofs_wreq_s            wreq,
  input  wire logic              wrHit,
  output logic [IDX_W-1:0]       rdIdx,
  input  wire logic [31:0]       rdData,
  input  wire logic              rdHit
);

  iqofs_wr_e        wrState;
  logic [IDX_W-1:0] awIdx;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             rPend;

  // Address and data are taken in either order; the write commits once both are held.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrState <= WR_IDLE;
      awready <= 1'b1;
      wready  <= 1'b1;
      awIdx   <= '0;
      wData   <= '0;
      wStrb   <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end
    else
    begin
      case (wrState)
        WR_IDLE:
        begin
          if (awvalid && awready)
          begin
            awIdx   <= awaddr[ADDR_W-1:2];
            awready <= 1'b0;
          end
          if (wvalid && wready)
          begin
            wData  <= wdata;
            wStrb  <= wstrb;
            wready <= 1'b0;
          end
          if ((!awready || awvalid) && (!wready || wvalid))
            wrState <= WR_COMMIT;
        end
        WR_COMMIT:
        begin
          bvalid  <= 1'b1;
          bresp   <= wrHit ? RESP_OKAY : RESP_SLVERR;
          wrState <= WR_RESP;
        end
        WR_RESP:
        begin
          if (bready)
          begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            wrState <= WR_IDLE;
          end
        end
        default:
          wrState <= WR_IDLE;
      endcase
    end
  end

  // The register strobe lasts exactly the commit cycle.
  assign wreq.en   = (wrState == WR_COMMIT);
  assign wreq.idx  = awIdx;
  assign wreq.data = wData;
  assign wreq.strb = wStrb;

  // Reads: address taken, data sampled one cycle later, held until rready.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      arready <= 1'b1;
      rdIdx   <= '0;
      rPend   <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rdIdx   <= araddr[ADDR_W-1:2];
      arready <= 1'b0;
      rPend   <= 1'b1;
    end
    else if (rPend)
    begin
      rdata  <= rdHit ? rdData : 32'h0000_0000;
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      rvalid <= 1'b1;
      rPend  <= 1'b0;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### verilog/iqofs_offset_pair.sv
// Applied offset pair that changes only on its auto-sync load strobe.
`timescale 1ns/100ps
`default_nettype none
module iqofs_offset_pair
  import iqofs_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic [OFS_W-1:0] firstIn,
  input  wire logic [OFS_W-1:0] secondIn,
  output logic      [OFS_W-1:0] firstOut,
  output logic      [OFS_W-1:0] secondOut
);

  // Both words move in the same edge so the pair never shows a mixed state.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      firstOut  <= RST_OFS[OFS_W-1:0];
      secondOut <= RST_OFS[OFS_W-1:0];
    end
    else if (load)
    begin
      firstOut  <= firstIn;
      secondOut <= secondIn;
    end
  end

endmodule
`default_nettype wire

// ### verilog/iqofs_pkg.sv
// Shared constants, register map and carrier types of the IQ offset register bank.
package iqofs_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_OFS_A     = 8'h08;
  localparam logic [7:0] IDX_PRESET_B  = 8'h09;
  localparam logic [7:0] IDX_OFS_C     = 8'h0A;
  localparam logic [7:0] IDX_OFS_D     = 8'h0B;
  localparam logic [7:0] IDX_GAIN_A    = 8'h0C;
  localparam logic [7:0] IDX_SYNC_CFG  = 8'h1E;
  localparam logic [7:0] IDX_STATUS    = 8'h1F;

  // Bus geometry.
  localparam int ADDR_W = 10;
  localparam int IDX_W  = 8;

  // Field widths and positions.
  localparam int OFS_W      = 13;
  localparam int OFS_LSB    = 0;
  localparam int GAIN_W     = 11;
  localparam int GAIN_LSB   = 0;
  localparam int PTR_W      = 3;
  localparam int PRESET_LSB = 13;
  localparam int SYNC_EN_BIT = 0;
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int CNT_W        = 8;

  // Writable bit masks; reserved bits are never stored and read as zero.
  localparam logic [15:0] MASK_OFS      = 16'h1FFF;
  localparam logic [15:0] MASK_PRESET_B = 16'hFFFF;
  localparam logic [15:0] MASK_GAIN     = 16'h07FF;
  localparam logic [15:0] MASK_SYNC_CFG = 16'h0001;

  // Reset values.
  localparam logic [15:0] RST_OFS      = 16'h0000;
  localparam logic [15:0] RST_PRESET_B = 16'h8000;
  localparam logic [15:0] RST_GAIN_A   = 16'h0400;
  localparam logic [15:0] RST_SYNC_CFG = 16'h0001;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel states, Gray coded along the path.
  typedef enum logic [1:0] {
    WR_IDLE   = 2'h0,
    WR_COMMIT = 2'h1,
    WR_RESP   = 2'h3
  } iqofs_wr_e;

  // One register write, valid for a single cycle.
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [31:0]      data;
    logic [3:0]       strb;
  } iqofs_wreq_s;

  // Correction words handed to the datapath.
  typedef struct packed {
    logic [OFS_W-1:0]  offA;
    logic [OFS_W-1:0]  offB;
    logic [OFS_W-1:0]  offC;
    logic [OFS_W-1:0]  offD;
    logic [GAIN_W-1:0] gainA;
  } iqofs_corr_s;

endpackage

// ### verilog/iqofs_regs.sv
// Register bank for IQ offset and gain correction and the FIFO read-pointer preset.
//
// What this block does
// [RULE_01] FIFO sync loads preset into read pointer.
// [RULE_02] Preset resets to 100; register resets 0x8000.
// [RULE_03] B, C, D offsets: 13 bits, reset zero.
// [RULE_04] Enabled channel-C offset write fires auto-sync.
// [RULE_05] Auto-sync applies C and D offsets together.
// [RULE_06] Channel-D write alone changes no applied offset.
// [RULE_07] Software writes D first, C last.
// [RULE_08] Gain A: 11-bit unsigned, point above bit 9.
// [RULE_09] Gain A register resets to 0x0400.
// [RULE_10] Software keeps reserved upper bits at zero.
// [RULE_11] A/B pair likewise; A write fires sync.
`timescale 1ns/100ps
`default_nettype none
module iqofs_regs
  import iqofs_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              fifoSyncIn,
  output logic [PTR_W-1:0]       fifoReadPtr,
  output logic                   fifoPtrLoad,
  output logic                   autoSyncPulse,
  output iqofs_corr_s            corr
);

  // The synchroniser needs at least two flops to settle a pin level.
  generate
    if (SYNC_STAGES < 2)
    begin : gBadStages
      $error("SYNC_STAGES must be at least 2.");
    end
  endgenerate

  iqofs_wreq_s            wreq;
  logic                   wrHit;
  logic [IDX_W-1:0]       rdIdx;
  logic [31:0]            rdData;
  logic                   rdHit;
  logic [15:0]            ofsA;
  logic [15:0]            presetB;
  logic [15:0]            ofsC;
  logic [15:0]            ofsD;
  logic [15:0]            gainA;
  logic [15:0]            syncCfg;
  logic [15:0]            next_ofsA;
  logic [15:0]            next_presetB;
  logic [15:0]            next_ofsC;
  logic [15:0]            next_ofsD;
  logic [15:0]            next_gainA;
  logic [15:0]            next_syncCfg;
  logic                   syncEn;
  logic                   abSync;
  logic                   cdSync;
  logic [SYNC_STAGES-1:0] syncChain;
  logic                   syncPrev;
  logic                   fifoSyncEvent;
  logic [CNT_W-1:0]       autoSyncCount;
  logic [OFS_W-1:0]       appA;
  logic [OFS_W-1:0]       appB;
  logic [OFS_W-1:0]       appC;
  logic [OFS_W-1:0]       appD;

  // Merge the low two byte lanes of a write into a register, keeping only writable bits.
  // Lanes 2 and 3 carry no register bits, so their strobes are ignored.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb,
                                          input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res & mask;
  endfunction

  iqofs_axil_slave uBus (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wreq    (wreq),
    .wrHit   (wrHit),
    .rdIdx   (rdIdx),
    .rdData  (rdData),
    .rdHit   (rdHit)
  );

  // Write decode; the status register is read only and refuses writes.
  // A refused write still answers, with an error response and no side effect.
  always_comb
  begin
    if (wreq.idx == IDX_OFS_A)
      wrHit = 1'b1;
    else if (wreq.idx == IDX_PRESET_B)
      wrHit = 1'b1;
    else if (wreq.idx == IDX_OFS_C)
      wrHit = 1'b1;
    else if (wreq.idx == IDX_OFS_D)
      wrHit = 1'b1;
    else if (wreq.idx == IDX_GAIN_A)
      wrHit = 1'b1;
    else if (wreq.idx == IDX_SYNC_CFG)
      wrHit = 1'b1;
    else
      wrHit = 1'b0;
  end

  // Candidate register values for the write in flight.
  assign next_ofsA    = merge16(ofsA, wreq.data, wreq.strb, MASK_OFS);
  assign next_presetB = merge16(presetB, wreq.data, wreq.strb, MASK_PRESET_B);
  assign next_ofsC    = merge16(ofsC, wreq.data, wreq.strb, MASK_OFS);
  assign next_ofsD    = merge16(ofsD, wreq.data, wreq.strb, MASK_OFS);
  assign next_gainA   = merge16(gainA, wreq.data, wreq.strb, MASK_GAIN);
  assign next_syncCfg = merge16(syncCfg, wreq.data, wreq.strb, MASK_SYNC_CFG);

  // Stored register words; reserved bits are masked off on every write.
  // Masking keeps factory bits at zero even when software writes ones there.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ofsA    <= RST_OFS; // RULE_03
      presetB <= RST_PRESET_B; // RULE_02
      ofsC    <= RST_OFS; // RULE_03
      ofsD    <= RST_OFS; // RULE_03
      gainA   <= RST_GAIN_A; // RULE_09
      syncCfg <= RST_SYNC_CFG;
    end
    else if (wreq.en)
    begin
      if (wreq.idx == IDX_OFS_A)
        ofsA <= next_ofsA;
      else if (wreq.idx == IDX_PRESET_B)
        presetB <= next_presetB;
      else if (wreq.idx == IDX_OFS_C)
        ofsC <= next_ofsC;
      else if (wreq.idx == IDX_OFS_D)
        ofsD <= next_ofsD; // RULE_06
      else if (wreq.idx == IDX_GAIN_A)
        gainA <= next_gainA; // RULE_08
      else if (wreq.idx == IDX_SYNC_CFG)
        syncCfg <= next_syncCfg;
    end
  end

  // Any write to the last register of a pair fires that pair's auto-sync when enabled.
  // The trigger ignores the byte strobes, so an empty write re-applies the stored pair.
  // Writing the partner register first keeps the datapath from seeing half an update.
  assign syncEn = syncCfg[SYNC_EN_BIT];
  assign abSync = wreq.en && (wreq.idx == IDX_OFS_A) && syncEn; // RULE_11
  assign cdSync = wreq.en && (wreq.idx == IDX_OFS_C) && syncEn; // RULE_04

  // A/B pair: the freshly written A word goes in with the stored B word.
  // B shares its register with the preset, so only bits 12:0 reach the pair.
  iqofs_offset_pair uPairAb (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .load      (abSync),
    .firstIn   (next_ofsA[OFS_LSB +: OFS_W]),
    .secondIn  (presetB[OFS_LSB +: OFS_W]),
    .firstOut  (appA),
    .secondOut (appB)
  );

  // C/D pair: the D word written earlier only reaches the datapath here.
  iqofs_offset_pair uPairCd (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .load      (cdSync), // RULE_05
    .firstIn   (next_ofsC[OFS_LSB +: OFS_W]),
    .secondIn  (ofsD[OFS_LSB +: OFS_W]), // RULE_06
    .firstOut  (appC),
    .secondOut (appD)
  );

  // Correction words; the gain is applied as soon as it is written.
  // The gain has no partner word, so it needs no sync to stay consistent.
  assign corr.offA  = appA;
  assign corr.offB  = appB;
  assign corr.offC  = appC;
  assign corr.offD  = appD;
  assign corr.gainA = gainA[GAIN_LSB +: GAIN_W]; // RULE_08

  // Pin synchroniser; only the settled stages feed the edge detector.
  // A pin still high at reset release yields one sync event two edges later.
  // The edge detector starts low, matching the idle level of the pin.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      syncChain <= '0;
      syncPrev  <= 1'b0;
    end
    else
    begin
      syncChain <= {syncChain[SYNC_STAGES-2:0], fifoSyncIn};
      syncPrev  <= syncChain[SYNC_STAGES-1];
    end
  end

  assign fifoSyncEvent = syncChain[SYNC_STAGES-1] && !syncPrev;

  // A FIFO sync loads the preset, setting the initial write-to-read spacing.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fifoReadPtr <= RST_PRESET_B[PRESET_LSB +: PTR_W]; // RULE_02
      fifoPtrLoad <= 1'b0;
    end
    else
    begin
      fifoPtrLoad <= fifoSyncEvent;
      if (fifoSyncEvent)
        fifoReadPtr <= presetB[PRESET_LSB +: PTR_W]; // RULE_01
    end
  end

  // Auto-sync pulse and a wrapping count of auto-syncs for software to watch.
  // The count wraps to zero on the 256th event; software compares two reads modulo 256.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      autoSyncPulse <= 1'b0;
      autoSyncCount <= '0;
    end
    else
    begin
      autoSyncPulse <= abSync || cdSync;
      if (abSync || cdSync)
        autoSyncCount <= autoSyncCount + 1'b1;
    end
  end

  // Read decode; narrow registers sit in the low bits, the rest reads zero.
  // Unmapped indices answer with an error response and zero data.
  always_comb
  begin
    rdData = 32'h0000_0000;
    rdHit  = 1'b1;
    if (rdIdx == IDX_OFS_A)
      rdData[15:0] = ofsA;
    else if (rdIdx == IDX_PRESET_B)
      rdData[15:0] = presetB;
    else if (rdIdx == IDX_OFS_C)
      rdData[15:0] = ofsC;
    else if (rdIdx == IDX_OFS_D)
      rdData[15:0] = ofsD;
    else if (rdIdx == IDX_GAIN_A)
      rdData[15:0] = gainA;
    else if (rdIdx == IDX_SYNC_CFG)
      rdData[15:0] = syncCfg;
    else if (rdIdx == IDX_STATUS)
    begin
      rdData[STAT_PTR_LSB +: PTR_W] = fifoReadPtr;
      rdData[STAT_CNT_LSB +: CNT_W] = autoSyncCount;
    end
    else
      rdHit = 1'b0;
  end

endmodule
`default_nettype wire
